// ==== core/lpc_pkg.sv ====
/*
  lpc_pkg: shared constants and carrier types for the low-power level and
  host port lock configuration bank.
  assumes: one 20 MHz clock, registers reached by a simple internal write/read
  strobe port decoded upstream by the host serial engine.
*/
package lpc_pkg;

  // clock rate and derived timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TICK_MS       = 20;            // 0.02 s period unit
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned PERIOD_ADD_IRQ = 10;           // interrupt mode offset
  localparam int unsigned PERIOD_ADD_ONE = 1;            // host-timed mode offset

  // register addresses
  localparam logic [15:0] ADDR_FAST_CAPTURE = 16'hE706;
  localparam logic [15:0] ADDR_LOWPOWER_LVL = 16'hEC00;
  localparam logic [15:0] ADDR_SECOND_CFG   = 16'hEC01;  // placed next to level reg

  // reset values
  localparam logic [7:0] RST_FAST_CAPTURE = 8'h00;
  localparam logic [7:0] RST_LOWPOWER_LVL = 8'h00;
  localparam logic [7:0] RST_SECOND_CFG   = 8'h00;

  // field positions
  localparam int unsigned THR_LSB      = 0;
  localparam int unsigned PERIOD_LSB   = 3;
  localparam int unsigned EXTREF_BIT   = 0;
  localparam int unsigned LOCK_BIT     = 1;
  localparam int unsigned INT0DIS_BIT  = 2;
  localparam int unsigned ACKPOL_BIT   = 5;

  // select pin toggles that move the port to SPI
  localparam logic [1:0] SPI_TOGGLES = 2'h3;

  // register write/read request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } lpc_req_t;

  // decoded configuration fields
  typedef struct packed {
    logic [2:0] thresholdSel;
    logic [4:0] periodCount;
    logic       externalRefSelect;
    logic       firstIntPinDisable;
    logic       ackPolarity;
  } lpc_cfg_t;

endpackage : lpc_pkg

// ==== core/lpc_period_timer.sv ====
/*
  lpc_period_timer: measurement period timer for the lowest-power monitor.
  assumes: start is a one-cycle pulse; period count sampled at start.
*/
`timescale 1ns/100ps
module lpc_period_timer #(
  parameter int unsigned TICK_CYCLES = lpc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // control
  input  wire logic       start,
  input  wire logic [4:0] periodCount,
  // status
  output logic            busy,
  output logic            done
);

  logic [$clog2(TICK_CYCLES)-1:0] tickCnt_q;  // cycles within one 0.02 s unit
  logic [5:0]                     unitCnt_q;  // remaining units
  logic                           tick;       // one-cycle 0.02 s enable

  assign tick = busy && (tickCnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

  // divider producing the 0.02 s enable
  always_ff @(posedge mclk) begin
    if (!resetn || start || tick) begin
      tickCnt_q <= '0;
    end else if (busy) begin
      tickCnt_q <= tickCnt_q + 1'b1;
    end
  end

  // period = 0.02 s * (count + 10)
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      unitCnt_q <= 6'h00;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        unitCnt_q <= 6'(periodCount) + 6'(lpc_pkg::PERIOD_ADD_IRQ);
        busy      <= 1'b1;
      end else if (tick) begin
        if (unitCnt_q == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        unitCnt_q <= unitCnt_q - 6'h01;
      end
    end
  end

  // a measurement pulse only comes in the cycle after the period was running
  done_after_busy_a: assert property (@(posedge mclk) disable iff (!resetn)
    done |-> $past(busy)) else $error("done without running period");

endmodule : lpc_period_timer

// ==== core/lpc_port_select.sv ====
/*
  lpc_port_select: host port arbitration between I2C and SPI.
  assumes: selPin already synchronised; writeSecond is a one-cycle pulse.
*/
`timescale 1ns/100ps
module lpc_port_select (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // inputs
  input  wire logic selPin,
  input  wire logic lockBit,
  input  wire logic writeSecond,
  // status
  output logic      spiActive,
  output logic      portLocked
);

  logic       selPrev_q;   // last sampled select level
  logic [1:0] toggles_q;   // toggle count toward SPI switch

  // edge history of the select pin
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      selPrev_q <= 1'b1;
    end else begin
      selPrev_q <= selPin;
    end
  end

  // toggle counter; frozen once locked
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      toggles_q <= 2'h0;
      spiActive <= 1'b0;
    end else if (!portLocked && !spiActive && (selPin != selPrev_q)) begin
      if (toggles_q == lpc_pkg::SPI_TOGGLES - 2'h1) begin
        spiActive <= 1'b1;
      end
      toggles_q <= toggles_q + 2'h1;
    end
  end

  // lock is sticky until reset; power mode changes never clear it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      portLocked <= 1'b0;
    end else if ((!spiActive && lockBit) || (spiActive && writeSecond)) begin
      portLocked <= 1'b1;
    end
  end

  locked_no_switch_a: assert property (@(posedge mclk) disable iff (!resetn)
    portLocked |=> spiActive == $past(spiActive)) else $error("port moved after lock");
  lock_sticks_a: assert property (@(posedge mclk) disable iff (!resetn)
    portLocked |=> portLocked) else $error("lock dropped");
  spi_write_lock_a: assert property (@(posedge mclk) disable iff (!resetn)
    spiActive && writeSecond |=> portLocked) else $error("spi write did not lock");

endmodule : lpc_port_select

// ==== core/lpc_config_bank.sv ====
/*
  lpc_config_bank: low-power level and second configuration registers with
  the host port lock, reference select and first interrupt gating.
  assumes: host serial engine presents decoded byte writes and reads on
  regReq with single-cycle strobes; select pin is asynchronous.
*/
`timescale 1ns/100ps
// Behaviour
// - three-bit field selects low-power threshold
// - interrupt mode period is 0.02s*(count+10)
// - reference bit picks internal or external
// - unlocked: three select toggles switch to SPI
// - I2C lock bit blocks later SPI switch
// - write to second config locks SPI
// - lock survives power mode changes
// - bit2 disables first interrupt in lowest power
// - second config bits 7:3 inert, reset zero
// - polarity bit sets ack output level
module lpc_config_bank #(
  parameter int unsigned TICK_CYCLES = lpc_pkg::TICK_CYCLES  // mclk cycles per 0.02 s unit
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // register access
  input  wire lpc_pkg::lpc_req_t regReq,
  output logic [7:0]            regRdata,
  output logic                  regRvalid,
  // power mode and monitor
  input  wire logic             lowestPowerMode,
  input  wire logic             irqModeStart,
  input  wire logic             firstIntRaw,
  input  wire logic             ackActive,
  // pins
  input  wire logic             selPinIn,
  output logic                  selAckOut,
  output logic                  selAckOe_n,
  output logic                  firstInterruptPin_n,
  // configuration outputs
  output lpc_pkg::lpc_cfg_t     cfg,
  output logic                  useExternalRef,
  output logic                  spiActive,
  output logic                  portLocked,
  output logic                  measureBusy,
  output logic                  measureDone
);

  logic [7:0] fastCap_q;      // fast capture configuration
  logic [7:0] lowLvl_q;       // low-power level configuration
  logic [2:0] second_q;       // live bits of second configuration
  logic       selMeta_q;      // synchroniser stage one
  logic       selSync_q;      // synchroniser stage two
  logic       wrSecond;       // write strobe to second config

  // true when a request hits the given address
  function automatic logic hit(input lpc_pkg::lpc_req_t r, input logic [15:0] a);
    hit = (r.addr == a);
  endfunction : hit

  assign wrSecond = regReq.wr && hit(regReq, lpc_pkg::ADDR_SECOND_CFG);

  // the select pin arrives from the host connector with no relation to
  // mclk; only the second stage is read, and both stages reset high to
  // match the idle level of the pin, so leaving reset is never an edge
  // two-stage synchroniser for the select pin
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      selMeta_q <= 1'b1;
      selSync_q <= 1'b1;
    end else begin
      selMeta_q <= selPinIn;
      selSync_q <= selMeta_q;
    end
  end

  // register writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fastCap_q <= lpc_pkg::RST_FAST_CAPTURE;
      lowLvl_q  <= lpc_pkg::RST_LOWPOWER_LVL;
      second_q  <= lpc_pkg::RST_SECOND_CFG[2:0];
    end else if (regReq.wr) begin
      if (hit(regReq, lpc_pkg::ADDR_FAST_CAPTURE)) begin
        fastCap_q <= regReq.wdata;
      end
      if (hit(regReq, lpc_pkg::ADDR_LOWPOWER_LVL)) begin
        lowLvl_q <= regReq.wdata;
      end
      if (wrSecond) begin
        second_q <= regReq.wdata[2:0];
      end
    end
  end

  // read path; inert bits of second config read zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      regRdata  <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regReq.rd;
      if (regReq.rd) begin
        if (hit(regReq, lpc_pkg::ADDR_FAST_CAPTURE)) begin
          regRdata <= fastCap_q;
        end else if (hit(regReq, lpc_pkg::ADDR_LOWPOWER_LVL)) begin
          regRdata <= lowLvl_q;
        end else if (hit(regReq, lpc_pkg::ADDR_SECOND_CFG)) begin
          regRdata <= {5'h00, second_q};
        end else begin
          regRdata <= 8'h00;  // unmapped reads zero
        end
      end
    end
  end

  // field decode
  always_comb begin
    cfg.thresholdSel       = lowLvl_q[lpc_pkg::THR_LSB +: 3];
    cfg.periodCount        = lowLvl_q[lpc_pkg::PERIOD_LSB +: 5];
    cfg.externalRefSelect  = second_q[lpc_pkg::EXTREF_BIT];
    cfg.firstIntPinDisable = second_q[lpc_pkg::INT0DIS_BIT];
    cfg.ackPolarity        = fastCap_q[lpc_pkg::ACKPOL_BIT];
  end

  assign useExternalRef = cfg.externalRefSelect;

  // first interrupt pin, active low, masked in lowest power mode when bit2 of second config is set
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      firstInterruptPin_n <= 1'b1;
    end else begin
      firstInterruptPin_n <= !(firstIntRaw &&
                               !(lowestPowerMode && cfg.firstIntPinDisable));
    end
  end

  // select/ack output: driven only while fast capture acknowledges
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      selAckOut  <= 1'b1;
      selAckOe_n <= 1'b1;
    end else begin
      selAckOut  <= cfg.ackPolarity ? ackActive : !ackActive;
      selAckOe_n <= !(ackActive && spiActive == 1'b0);
    end
  end

  // the lock lives in the arbiter rather than in second_q, so that a later
  // write of zero to the lock bit cannot release it; only resetn can
  // port arbitration
  lpc_port_select u_port (
    .mclk        (mclk),
    .resetn      (resetn),
    .selPin      (selSync_q),
    .lockBit     (second_q[lpc_pkg::LOCK_BIT]),
    .writeSecond (wrSecond),
    .spiActive   (spiActive),
    .portLocked  (portLocked)
  );

  // period timer; host-timed mode just uses no start
  lpc_period_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .mclk        (mclk),
    .resetn      (resetn),
    .start       (irqModeStart && lowestPowerMode),
    .periodCount (cfg.periodCount),
    .busy        (measureBusy),
    .done        (measureDone)
  );

  // write checks compare what the bank drives with what the host wrote a
  // cycle earlier, so a broken decode or a lost write shows up here;
  // ack_polarity_a restates the expression that drives selAckOut

  // first interrupt gate
  int0_masked_a: assert property (@(posedge mclk) disable iff (!resetn)
    lowestPowerMode && cfg.firstIntPinDisable |=> firstInterruptPin_n)
    else $error("first interrupt not masked");
  int0_follow_a: assert property (@(posedge mclk) disable iff (!resetn)
    !lowestPowerMode |=> firstInterruptPin_n == !$past(firstIntRaw))
    else $error("first interrupt not following request");

  // second configuration contents and read back
  inert_bits_a: assert property (@(posedge mclk) disable iff (!resetn)
    regRvalid && $past(hit(regReq, lpc_pkg::ADDR_SECOND_CFG)) |-> regRdata[7:3] == 5'h00)
    else $error("inert bits read nonzero");
  second_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    wrSecond |=> second_q == $past(regReq.wdata[2:0]))
    else $error("second config write lost");
  ref_select_a: assert property (@(posedge mclk) disable iff (!resetn)
    wrSecond |=> useExternalRef == $past(regReq.wdata[lpc_pkg::EXTREF_BIT]))
    else $error("reference select not taken from write");

  // low-power level field
  threshold_a: assert property (@(posedge mclk) disable iff (!resetn)
    regReq.wr && hit(regReq, lpc_pkg::ADDR_LOWPOWER_LVL)
    |=> cfg.thresholdSel == $past(regReq.wdata[2:0]))
    else $error("threshold field wrong");
  level_readback_a: assert property (@(posedge mclk) disable iff (!resetn)
    regReq.rd && hit(regReq, lpc_pkg::ADDR_LOWPOWER_LVL) |=> regRdata == $past(lowLvl_q))
    else $error("level register read back wrong");

  // fast capture acknowledge output
  ack_polarity_a: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 selAckOut == ($past(cfg.ackPolarity) ~^ $past(ackActive)))
    else $error("ack polarity wrong");
  ack_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
    !selAckOe_n |-> $past(ackActive) && !$past(spiActive))
    else $error("ack driven outside an acknowledge");

  // port selection seen from the bank
  i2c_lock_a: assert property (@(posedge mclk) disable iff (!resetn)
    !spiActive && second_q[lpc_pkg::LOCK_BIT] |=> portLocked)
    else $error("lock bit did not lock the port");
  spi_needs_unlock_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(spiActive) |-> !$past(portLocked))
    else $error("switched to SPI while locked");

  // measurement start gating
  start_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    !measureBusy && irqModeStart && !lowestPowerMode |=> !measureBusy)
    else $error("measurement started outside lowest power mode");

  // main scenarios
  lock_cover_c: cover property (@(posedge mclk) $rose(portLocked));
  spi_cover_c: cover property (@(posedge mclk) $rose(spiActive));
  done_cover_c: cover property (@(posedge mclk) measureDone);
  masked_cover_c: cover property (@(posedge mclk)
    lowestPowerMode && cfg.firstIntPinDisable && firstIntRaw);
  ack_high_cover_c: cover property (@(posedge mclk)
    !selAckOe_n && cfg.ackPolarity);

endmodule : lpc_config_bank

// ==== verification/lpc_host_model.sv ====
/*
  lpc_host_model: host side of the register port and of the select pin.
  assumes: the bench calls its tasks from one process; single mclk domain.
*/
`timescale 1ns/100ps
module lpc_host_model (
  // clock
  input  wire logic         mclk,
  // host outputs
  output lpc_pkg::lpc_req_t regReq,
  output logic              selPin
);
  // select idles high, the level the synchroniser resets to, so no false edge
  initial begin
    regReq = '0;
    selPin = 1'b1;
  end
  // one byte access, strobe up for exactly one edge
  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    regReq <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge mclk);
    // released lines show the inverse, never the stale value
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : access
  // on I2C the host takes the lock itself
  task automatic lockI2c();
    access(1'b1, lpc_pkg::ADDR_SECOND_CFG, 8'h02);
  endtask : lockI2c
  // n toggles, spaced well past the two-stage synchroniser
  task automatic toggleSel(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      selPin <= ~selPin;
    end
  endtask : toggleSel
  // host-timed mode: the device keeps no timer, so the host waits count+1 ticks
  task automatic hostWait(input logic [4:0] cnt, input int tick);
    repeat ((int'(cnt) + 1) * tick) @(posedge mclk);
  endtask : hostWait
endmodule : lpc_host_model

// ==== verification/lpc_config_bank_test.sv ====
/*
  lpc_config_bank_test: self-checking bench for the config bank.
  assumes: lpc_host_model drives the register port; bank built with a short period unit.
*/
`timescale 1ns/100ps
module lpc_config_bank_test;
  logic              mclk = 1'b0;          // 20 MHz
  logic              resetn;               // sync, active low
  lpc_pkg::lpc_req_t regReq;               // from host model
  logic [7:0]        regRdata;
  logic              regRvalid;
  logic              lowestPowerMode, irqModeStart, firstIntRaw, ackActive;
  logic              selPinIn, selAckOut, selAckOe_n, firstInterruptPin_n;
  lpc_pkg::lpc_cfg_t cfg;
  logic              useExternalRef, spiActive, portLocked, measureBusy, measureDone;
  logic [7:0]        expQ[$];              // expected read data, oldest first
  logic [7:0]        lvl;
  int                seed, miscompares = 0, checksDone = 0;
  int                cycles;               // cycles from start to done
  localparam int unsigned TICK = 4;        // short 0.02 s unit so a period fits the run

  always #25 mclk = ~mclk;

  lpc_config_bank #(.TICK_CYCLES(TICK))
  i_lpc_config_bank (.mclk(mclk), .resetn(resetn), .regReq(regReq),
    .regRdata(regRdata), .regRvalid(regRvalid), .lowestPowerMode(lowestPowerMode),
    .irqModeStart(irqModeStart), .firstIntRaw(firstIntRaw), .ackActive(ackActive),
    .selPinIn(selPinIn), .selAckOut(selAckOut), .selAckOe_n(selAckOe_n),
    .firstInterruptPin_n(firstInterruptPin_n), .cfg(cfg), .useExternalRef(useExternalRef),
    .spiActive(spiActive), .portLocked(portLocked), .measureBusy(measureBusy),
    .measureDone(measureDone));
  lpc_host_model i_lpc_host_model (.mclk(mclk), .regReq(regReq), .selPin(selPinIn));

  // byte compare, used for read data and for multi-bit fields
  task automatic cmpByte(input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmpByte
  // single status or pin level, sampled mid-cycle
  task automatic cmpBit(input logic e, input logic g);
    checksDone++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmpBit
  task automatic giveVerdict();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : giveVerdict
  // read watcher: mid-cycle, so the valid pulse is settled
  always @(negedge mclk) begin
    if (regRvalid === 1'b1) cmpByte(expQ.pop_front(), regRdata);
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_lpc_host_model.access(1'b1, a, d);
  endtask : wr
  task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
    expQ.push_back(e);
    i_lpc_host_model.access(1'b0, a, 8'h00);
    @(posedge mclk);
  endtask : rdChk
  // let writes and the synchroniser settle, then look mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  task automatic pulseReset();
    @(posedge mclk) resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
  endtask : pulseReset

  initial begin
    seed = 32'h0574;
    resetn = 1'b0;
    {lowestPowerMode, irqModeStart, firstIntRaw, ackActive} = 4'h0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    rdChk(lpc_pkg::ADDR_LOWPOWER_LVL, lpc_pkg::RST_LOWPOWER_LVL);
    rdChk(lpc_pkg::ADDR_SECOND_CFG, lpc_pkg::RST_SECOND_CFG);
    rdChk(16'h1234, 8'h00); // unmapped reads zero
    lvl = 8'($random(seed));
    wr(lpc_pkg::ADDR_LOWPOWER_LVL, lvl);
    rdChk(lpc_pkg::ADDR_LOWPOWER_LVL, lvl);
    cmpByte({5'h00, lvl[2:0]}, {5'h00, cfg.thresholdSel});
    cmpByte({3'h0, lvl[7:3]}, {3'h0, cfg.periodCount});
    // a start outside the lowest mode must not run the timer
    @(posedge mclk) irqModeStart <= 1'b1;
    @(posedge mclk) irqModeStart <= 1'b0;
    settle(1);
    cmpBit(1'b0, measureBusy);
    // interrupt-mode measurement starts in the lowest mode
    @(posedge mclk) lowestPowerMode <= 1'b1;
    firstIntRaw <= 1'b1;
    @(posedge mclk) irqModeStart <= 1'b1;
    @(posedge mclk) irqModeStart <= 1'b0;
    cycles = 0;
    @(negedge mclk);
    cmpBit(1'b1, measureBusy);
    while (measureDone !== 1'b1 && cycles < 1000) begin
      @(negedge mclk);
      cycles++;
    end
    cmpByte(8'((int'(lvl[7:3]) + lpc_pkg::PERIOD_ADD_IRQ) * TICK), 8'(cycles));
    @(negedge mclk);
    cmpBit(1'b0, measureDone);
    i_lpc_host_model.hostWait(5'h01, 2);
    // reserved bits set too: they must read back zero
    wr(lpc_pkg::ADDR_SECOND_CFG, 8'hFD);
    rdChk(lpc_pkg::ADDR_SECOND_CFG, 8'h05);
    settle(2);
    cmpBit(1'b1, useExternalRef);
    cmpBit(1'b1, firstInterruptPin_n);
    wr(lpc_pkg::ADDR_SECOND_CFG, 8'h00);
    settle(2);
    cmpBit(1'b0, useExternalRef);
    cmpBit(1'b0, firstInterruptPin_n);
    // ack polarity both ways, I2C still active
    @(posedge mclk) ackActive <= 1'b1;
    wr(lpc_pkg::ADDR_FAST_CAPTURE, 8'h20);
    settle(2);
    cmpBit(1'b1, selAckOut);
    cmpBit(1'b0, selAckOe_n);
    wr(lpc_pkg::ADDR_FAST_CAPTURE, 8'h00);
    settle(2);
    cmpBit(1'b0, selAckOut);
    @(posedge mclk) ackActive <= 1'b0;
    // lock on I2C, then toggles must be ignored
    i_lpc_host_model.lockI2c();
    // an even count leaves the pin at its idle high level for the reset
    i_lpc_host_model.toggleSel(4);
    settle(6);
    cmpBit(1'b1, portLocked);
    cmpBit(1'b0, spiActive);
    pulseReset();
    settle(1);
    cmpBit(1'b0, portLocked);
    rdChk(lpc_pkg::ADDR_SECOND_CFG, lpc_pkg::RST_SECOND_CFG);
    // unlocked: two toggles are not enough, the third moves to SPI
    i_lpc_host_model.toggleSel(2);
    settle(6);
    cmpBit(1'b0, spiActive);
    i_lpc_host_model.toggleSel(1);
    settle(6);
    cmpBit(1'b1, spiActive);
    cmpBit(1'b0, portLocked);
    wr(lpc_pkg::ADDR_SECOND_CFG, 8'h00);
    settle(2);
    cmpBit(1'b1, portLocked);
    // power mode changes and more toggles leave the choice alone
    @(posedge mclk) lowestPowerMode <= 1'b0;
    settle(3);
    @(posedge mclk) lowestPowerMode <= 1'b1;
    i_lpc_host_model.toggleSel(3);
    settle(6);
    cmpBit(1'b1, spiActive);
    cmpBit(1'b1, portLocked);
    giveVerdict();
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    giveVerdict();
  end
endmodule : lpc_config_bank_test
